// File: shared/bridge_pkg.sv
// Constants, types and field layouts of the USB-to-UART bridge control block.
// Assumes a 100 MHz system clock and a 48 MHz reference for baud arithmetic.
package bridge_pkg;

	// ------------------------------------------------------------------
	// Clocks and baud arithmetic
	// ------------------------------------------------------------------
	localparam int CLK_HZ     = 100_000_000;
	localparam int REF_HZ     = 48_000_000;
	localparam int REF_STEP   = REF_HZ / 1_000_000;
	localparam int REF_MOD    = CLK_HZ / 1_000_000;
	localparam int PRE_SLOW   = 4;
	localparam int PRE_FAST   = 1;
	localparam logic [21:0] PRE_LIMIT = 22'h00016d;
	localparam logic [21:0] BAUD_RST  = 22'h002580;

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_BAUD = 4'h4;
	localparam logic [3:0] OFF_STAT = 4'h8;
	localparam logic [3:0] OFF_DIV  = 4'hc;
	localparam int ERR_LSB = 1;

	// ------------------------------------------------------------------
	// Frame format and flow control encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] DLEN_5    = 2'h0;
	localparam logic [1:0] DLEN_8    = 2'h3;
	localparam logic [1:0] STOP_1    = 2'h0;
	localparam logic [1:0] STOP_15   = 2'h1;
	localparam logic [2:0] PAR_NONE  = 3'h0;
	localparam logic [2:0] PAR_EVEN  = 3'h1;
	localparam logic [2:0] PAR_ODD   = 3'h2;
	localparam logic [2:0] PAR_MARK  = 3'h3;
	localparam logic [1:0] FLOW_NONE = 2'h0;
	localparam logic [1:0] FLOW_RTS  = 2'h1;
	localparam logic [1:0] FLOW_DSR  = 2'h2;
	localparam logic [1:0] FLOW_XON  = 2'h3;
	localparam logic [7:0] XON_CHAR  = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;

	typedef struct packed {
		logic       wake_en;
		logic [1:0] flow;
		logic [2:0] parity;
		logic [1:0] stop;
		logic [1:0] dlen;
	} cfg_s;

	localparam cfg_s CFG_RST = 10'h003;

	typedef struct packed {
		logic ri;
		logic dcd;
		logic dsr;
		logic cts;
		logic xoff;
		logic ovr;
		logic perr;
		logic ferr;
		logic sleep;
	} stat_s;

	typedef enum logic [2:0] {
		SL_ENUM   = 3'b001,
		SL_ACTIVE = 3'b010,
		SL_SUSP   = 3'b100
	} sleep_e;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_BITS  = 4'b0100,
		RX_STOP  = 4'b1000
	} rx_e;

endpackage : bridge_pkg

// File: design/uart_bridge_ctl.sv
// Suspend sequencing, UART framing, baud generation and flow control.
// Assumes USB bus events arrive as one-cycle pulses synchronous to clk_i.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// - Bus suspend signalling moves the block into its suspend state.
// - In suspend both sleep indicators are asserted, high and low flavour.
// - After reset the indicators stay asserted until configuration is done or a suspend is exited.
// - Detected or self-generated resume leaves suspend.
// - A bus reset from the host leaves suspend.
// - A device reset leaves suspend regardless of bus activity.
// - With remote wakeup enabled, grounding the rouse pin leaves suspend.
// - Any exit from suspend except device reset deasserts both indicators.
// - The function side carries all payload and the UART control commands.
// - The UART has data lines plus RTS, CTS, DSR, DTR, DCD and RI.
// - Flow control is RTS/CTS, DSR/DTR or Xon/Xoff, as selected.
// - Frames have 5 to 8 data bits, 1, 1.5 or 2 stops, five parity kinds.
// - Baud rates from 300 to 3000000 are accepted as configured.
// - Divider uses prescale 4 up to 365 baud, 1 above, rounded to nearest.
module uart_bridge_ctl (
	input  wire logic                           clk_i,
	input  wire logic                           nrst_i,
	input  wire logic                           suspend_det_i,
	input  wire logic                           resume_det_i,
	input  wire logic                           bus_reset_i,
	input  wire logic                           config_done_i,
	input  wire logic                           remote_rouse_n_i,
	output logic                                resume_req_o,
	output logic                                sleep_ind_high_o,
	output logic                                sleep_ind_low_o,
	input  wire logic [bridge_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [bridge_pkg::DATA_W-1:0]  wdata_i,
	input  wire logic                           wr_i,
	input  wire logic                           rd_i,
	output logic      [bridge_pkg::DATA_W-1:0]  rdata_o,
	input  wire logic                           tx_valid_i,
	input  wire logic [7:0]                     tx_data_i,
	output logic                                tx_ready_o,
	output logic                                rx_valid_o,
	output logic      [7:0]                     rx_data_o,
	input  wire logic                           rx_ready_i,
	output logic                                txd_o,
	input  wire logic                           rxd_i,
	output logic                                rts_n_o,
	input  wire logic                           cts_n_i,
	output logic                                dtr_n_o,
	input  wire logic                           dsr_n_i,
	input  wire logic                           dcd_n_i,
	input  wire logic                           ri_n_i
);
	import bridge_pkg::*;

	// Divider of the reset rate, which lies above the slow-prescale limit
	localparam logic [16:0] DIV_RST  =
		17'(REF_HZ / (2 * PRE_FAST * int'(BAUD_RST)));
	localparam logic [19:0] HALF_RST = 20'(PRE_FAST) * 20'(DIV_RST);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [3:0] dbits(input cfg_s c);
		return 4'h5 + {2'h0, c.dlen};
	endfunction : dbits

	function automatic logic par_bit(input logic [7:0] d, input logic [2:0] p);
		case (p)
			PAR_EVEN: return ^d;
			PAR_ODD:  return ~^d;
			PAR_MARK: return 1'b1;
			default:  return 1'b0;
		endcase
	endfunction : par_bit

	function automatic logic [7:0] dmask(input logic [7:0] d, input cfg_s c);
		return d & (8'hff >> (4'h8 - dbits(c)));
	endfunction : dmask

	function automatic logic [4:0] frame_halves(input cfg_s c);
		logic [4:0] s;
		s = 5'h4;
		if (c.stop == STOP_1)
			s = 5'h2;
		else if (c.stop == STOP_15 && c.dlen == DLEN_5)
			s = 5'h3;
		return {dbits(c), 1'b0} + 5'h2 + s +
			((c.parity != PAR_NONE) ? 5'h2 : 5'h0);
	endfunction : frame_halves

	function automatic logic [11:0] tx_frame(input logic [7:0] d,
		input cfg_s c);
		logic [11:0] f;
		logic [7:0]  m;
		f = 12'hffe;
		m = dmask(d, c);
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < dbits(c))
				f[i + 1] = m[i];
		end
		if (c.parity != PAR_NONE)
			f[dbits(c) + 4'h1] = par_bit(m, c.parity);
		return f;
	endfunction : tx_frame

	function automatic logic [2:0] pre_of(input logic [21:0] r);
		return (r <= PRE_LIMIT) ? 3'(PRE_SLOW) : 3'(PRE_FAST);
	endfunction : pre_of

	// The reference frequency needs 26 bits, so the arithmetic is 32 wide
	function automatic logic [16:0] baud_div(input logic [21:0] r);
		logic [31:0] num;
		num = 32'(REF_HZ) / (32'h2 * 32'(pre_of(r)));
		if (r == 22'h0)
			return 17'h1;
		return 17'((num + 32'(r >> 1)) / 32'(r));
	endfunction : baud_div

	// ------------------------------------------------------------------
	// Register port and configuration
	// ------------------------------------------------------------------
	cfg_s        cfg_reg;
	logic [21:0] rate_reg;
	logic [16:0] div_reg;
	logic [19:0] half_reg;
	logic [2:0]  err_reg;
	logic        xoff_reg;
	stat_s       stat;
	sleep_e      sl_reg, sl_next;

	assign stat = '{ri: ~ri_n_i, dcd: ~dcd_n_i, dsr: ~dsr_n_i,
		cts: ~cts_n_i, xoff: xoff_reg, ovr: err_reg[2],
		perr: err_reg[1], ferr: err_reg[0], sleep: sl_reg != SL_ACTIVE};

	// Host commands arrive here; rate writes recompute the divider once
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_reg  <= CFG_RST;
			rate_reg <= BAUD_RST;
			div_reg  <= DIV_RST;
			half_reg <= HALF_RST;
		end else if (wr_i) begin
			if (addr_i == OFF_CTRL)
				cfg_reg <= cfg_s'(wdata_i[9:0]);
			if (addr_i == OFF_BAUD) begin
				rate_reg <= wdata_i[21:0];
				div_reg  <= baud_div(wdata_i[21:0]);
				half_reg <= 20'(pre_of(wdata_i[21:0])) *
					20'(baud_div(wdata_i[21:0]));
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_o <= 32'h0;
		else if (rd_i) begin
			case (addr_i)
				OFF_CTRL: rdata_o <= {22'h0, cfg_reg};
				OFF_BAUD: rdata_o <= {10'h0, rate_reg};
				OFF_STAT: rdata_o <= {23'h0, stat};
				OFF_DIV:  rdata_o <= {15'h0, div_reg};
				default:  rdata_o <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Suspend sequencing
	// ------------------------------------------------------------------
	logic rouse_d_reg;
	logic wake_go;

	// Edge, not level: a pin held low must not re-wake after each suspend
	assign wake_go = cfg_reg.wake_en & rouse_d_reg & ~remote_rouse_n_i;

	always_comb begin
		sl_next = sl_reg;
		case (sl_reg)
			SL_ENUM: begin
				if (suspend_det_i)
					sl_next = SL_SUSP;
				else if (config_done_i)
					sl_next = SL_ACTIVE;
			end
			SL_ACTIVE: begin
				if (suspend_det_i)
					sl_next = SL_SUSP;
			end
			SL_SUSP: begin
				if (resume_det_i || bus_reset_i || wake_go)
					sl_next = SL_ACTIVE;
			end
			default: sl_next = SL_ENUM;
		endcase
	end

	// Device reset always lands in the enumeration state
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sl_reg       <= SL_ENUM;
			rouse_d_reg  <= 1'b1;
			resume_req_o <= 1'b0;
		end else begin
			sl_reg       <= sl_next;
			rouse_d_reg  <= remote_rouse_n_i;
			resume_req_o <= (sl_reg == SL_SUSP) && wake_go;
		end
	end

	assign sleep_ind_high_o = ~sl_reg[1];
	assign sleep_ind_low_o  = sl_reg[1];

	// ------------------------------------------------------------------
	// Baud timing
	// ------------------------------------------------------------------
	logic [7:0] nco_reg;
	logic       ref_tick;

	// Fractional 48 MHz tick on the 100 MHz clock, jitter one clk period
	assign ref_tick = (nco_reg + 8'(REF_STEP)) >= 8'(REF_MOD);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			nco_reg <= 8'h0;
		else if (ref_tick)
			nco_reg <= nco_reg + 8'(REF_STEP) - 8'(REF_MOD);
		else
			nco_reg <= nco_reg + 8'(REF_STEP);
	end

	// ------------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------------
	logic [11:0] tx_sh_reg;
	logic [4:0]  tx_half_reg;
	logic [19:0] tx_tmr_reg;
	logic        tx_ph_reg;
	logic        tx_tick, tx_stop, tx_load;

	assign tx_tick = ref_tick && tx_tmr_reg == half_reg - 20'h1;
	assign tx_stop = (cfg_reg.flow == FLOW_RTS && cts_n_i) ||
		(cfg_reg.flow == FLOW_DSR && dsr_n_i) ||
		(cfg_reg.flow == FLOW_XON && xoff_reg);
	assign tx_ready_o = tx_half_reg == 5'h0 && !tx_stop;
	assign tx_load    = tx_valid_i && tx_ready_o;
	assign txd_o      = tx_sh_reg[0];

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_sh_reg   <= 12'hfff;
			tx_half_reg <= 5'h0;
			tx_tmr_reg  <= 20'h0;
			tx_ph_reg   <= 1'b0;
		end else if (tx_load) begin
			tx_sh_reg   <= tx_frame(tx_data_i, cfg_reg);
			tx_half_reg <= frame_halves(cfg_reg);
			tx_tmr_reg  <= 20'h0;
			tx_ph_reg   <= 1'b0;
		end else if (ref_tick) begin
			tx_tmr_reg <= tx_tick ? 20'h0 : tx_tmr_reg + 20'h1;
			if (tx_tick && tx_half_reg != 5'h0) begin
				tx_half_reg <= tx_half_reg - 5'h1;
				tx_ph_reg   <= ~tx_ph_reg;
				if (tx_ph_reg)
					tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
			end
		end
	end

	// ------------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------------
	rx_e         rx_reg;
	logic [8:0]  rx_sh_reg, rx_word;
	logic [3:0]  rx_cnt_reg, rx_nb;
	logic [19:0] rx_tmr_reg;
	logic        rx_ph_reg, rx_half, rx_done, rx_ctl, rx_bad_par;
	logic        rx_line_reg;

	// Start needs a falling edge, so a line held low after a framing
	// error is not taken for a new start bit
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rx_line_reg <= 1'b1;
		else
			rx_line_reg <= rxd_i;
	end

	assign rx_half = ref_tick && rx_tmr_reg == half_reg - 20'h1;
	assign rx_nb   = dbits(cfg_reg) +
		((cfg_reg.parity != PAR_NONE) ? 4'h1 : 4'h0);
	assign rx_word = rx_sh_reg >> (4'h9 - rx_nb);
	assign rx_done = rx_reg == RX_STOP && rx_half && rx_ph_reg;
	assign rx_ctl  = cfg_reg.flow == FLOW_XON &&
		(rx_word[7:0] == XON_CHAR || rx_word[7:0] == XOFF_CHAR);
	assign rx_bad_par = cfg_reg.parity != PAR_NONE &&
		rx_word[dbits(cfg_reg)] !=
		par_bit(dmask(rx_word[7:0], cfg_reg), cfg_reg.parity);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_reg     <= RX_IDLE;
			rx_sh_reg  <= 9'h0;
			rx_cnt_reg <= 4'h0;
			rx_tmr_reg <= 20'h0;
			rx_ph_reg  <= 1'b0;
		end else begin
			if (rx_reg == RX_IDLE || rx_half)
				rx_tmr_reg <= 20'h0;
			else if (ref_tick)
				rx_tmr_reg <= rx_tmr_reg + 20'h1;
			if (rx_half && rx_reg != RX_START)
				rx_ph_reg <= ~rx_ph_reg;
			case (rx_reg)
				RX_IDLE: begin
					rx_ph_reg  <= 1'b0;
					rx_cnt_reg <= 4'h0;
					if (rx_line_reg && !rxd_i)
						rx_reg <= RX_START;
				end
				RX_START: begin
					// A glitch shorter than half a bit is dropped
					if (rx_half)
						rx_reg <= rxd_i ? RX_IDLE : RX_BITS;
				end
				RX_BITS: begin
					if (rx_half && rx_ph_reg) begin
						rx_sh_reg  <= {rxd_i, rx_sh_reg[8:1]};
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
						if (rx_cnt_reg == rx_nb - 4'h1)
							rx_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_done)
						rx_reg <= RX_IDLE;
				end
				default: rx_reg <= RX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Two-entry receive buffer and receive-side flags
	// ------------------------------------------------------------------
	logic [7:0] buf_mem [2];
	logic [1:0] buf_cnt_reg;
	logic       wp_reg, rp_reg, push, pop, full;

	// The UART cannot be stalled, so a full buffer overruns; RTS/DTR
	// warn the far end one word early
	assign full       = buf_cnt_reg == 2'h2;
	assign pop        = rx_valid_o && rx_ready_i;
	assign push       = rx_done && rxd_i && !rx_ctl && (!full || pop);
	assign rx_valid_o = buf_cnt_reg != 2'h0;
	assign rx_data_o  = buf_mem[rp_reg];
	assign rts_n_o    = cfg_reg.flow == FLOW_RTS && buf_cnt_reg != 2'h0;
	assign dtr_n_o    = cfg_reg.flow == FLOW_DSR && buf_cnt_reg != 2'h0;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			buf_mem[0]  <= 8'h0;
			buf_mem[1]  <= 8'h0;
			buf_cnt_reg <= 2'h0;
			wp_reg      <= 1'b0;
			rp_reg      <= 1'b0;
		end else begin
			if (push) begin
				buf_mem[wp_reg] <= dmask(rx_word[7:0], cfg_reg);
				wp_reg          <= ~wp_reg;
			end
			if (pop)
				rp_reg <= ~rp_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// Error flags clear by writing one; a new error in that cycle wins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			err_reg  <= 3'h0;
			xoff_reg <= 1'b0;
		end else begin
			err_reg <= (err_reg & ~((wr_i && addr_i == OFF_STAT) ?
				wdata_i[ERR_LSB +: 3] : 3'h0)) |
				{rx_done && rxd_i && !rx_ctl && full && !pop,
				rx_done && rx_bad_par, rx_done && !rxd_i};
			if (cfg_reg.flow != FLOW_XON)
				xoff_reg <= 1'b0;
			else if (rx_done && rx_ctl)
				xoff_reg <= rx_word[7:0] == XOFF_CHAR;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_susp;
		sl_reg == SL_SUSP;
	endsequence
	sequence s_exit;
		s_susp ##0 (resume_det_i || bus_reset_i || wake_go);
	endsequence

	a_susp_enter: assert property (
		sl_reg == SL_ACTIVE && suspend_det_i |=> s_susp)
		else $error("suspend not entered");
	a_susp_ind: assert property (
		s_susp |-> sleep_ind_high_o && !sleep_ind_low_o)
		else $error("indicators off in suspend");
	a_enum_hold: assert property (
		sl_reg == SL_ENUM && !config_done_i |=>
		sleep_ind_high_o && !sleep_ind_low_o)
		else $error("indicators dropped before configuration");
	a_resume_exit: assert property (
		s_susp ##0 resume_det_i |=> sl_reg == SL_ACTIVE)
		else $error("resume did not exit suspend");
	a_busrst_exit: assert property (
		s_susp ##0 bus_reset_i |=> sl_reg == SL_ACTIVE)
		else $error("bus reset did not exit suspend");
	a_wake_exit: assert property (
		s_susp ##0 (cfg_reg.wake_en && $fell(remote_rouse_n_i)) |=>
		sl_reg == SL_ACTIVE && resume_req_o)
		else $error("remote wake did not exit suspend");
	a_exit_ind: assert property (
		s_exit |=> !sleep_ind_high_o && sleep_ind_low_o)
		else $error("indicators held after exit");
	a_flow_gate: assert property (
		cfg_reg.flow == FLOW_RTS && cts_n_i |-> !tx_ready_o)
		else $error("sent while clear-to-send off");
	a_stop_five: assert property (
		tx_load && cfg_reg.dlen == DLEN_5 && cfg_reg.stop == STOP_15 |=>
		tx_half_reg == (($past(cfg_reg.parity) == PAR_NONE) ?
		5'h0f : 5'h11))
		else $error("five-bit frame lacks 1.5 stop");
	a_stop_eight: assert property (
		tx_load && cfg_reg.dlen == DLEN_8 && cfg_reg.stop == STOP_15 |=>
		tx_half_reg == (($past(cfg_reg.parity) == PAR_NONE) ?
		5'h16 : 5'h18))
		else $error("eight-bit frame not widened to two stops");
	a_baud_slow: assert property (
		wr_i && addr_i == OFF_BAUD && wdata_i[21:0] <= PRE_LIMIT &&
		wdata_i[21:0] != 22'h0 |=>
		half_reg == {1'b0, div_reg, 2'h0} &&
		32'(div_reg) == (32'(REF_HZ / (2 * PRE_SLOW)) +
		(32'($past(wdata_i[21:0])) >> 1)) /
		32'($past(wdata_i[21:0])))
		else $error("slow-rate divider wrong");
	a_idle_line: assert property (
		tx_half_reg == 5'h0 ##1 tx_half_reg == 5'h0 |-> txd_o)
		else $error("transmit line not idle high");

endmodule : uart_bridge_ctl

// File: verif/uart_far_end.sv
// Far-end serial device model on the UART data and handshake pins.
// Assumes the bench sets bit_ns to the bit time it configured.
`timescale 1ns/1ps
module uart_far_end (
	input  wire logic clk_i,
	input  wire logic txd_i,
	input  wire logic rts_n_i,
	input  wire logic dtr_n_i,
	output logic      rxd_o
);
	// ----------
	// Frame driver and sampler
	// ----------
	realtime bit_ns = 1000.0;
	initial rxd_o = 1'b1;
	// Edges follow absolute time, so clock alignment never accumulates
	task automatic send(input logic [7:0] d, input int nb, hp,
		input logic pb, sl);
		realtime t0;
		logic    v;
		wait (rts_n_i === 1'b0 && dtr_n_i === 1'b0);
		t0 = $realtime;
		for (int k = 0; k <= nb + hp + 2; k++) begin
			v = (k == 0) ? 1'b0 : (k <= nb) ? d[k-1] :
				(hp != 0 && k == nb + 1) ? pb : (k == nb + hp + 1) ? sl : 1'b1;
			#(t0 + k * bit_ns - $realtime);
			@(posedge clk_i) rxd_o <= v;
		end
		#(bit_ns);
	endtask : send
	task automatic grab(input int nb, hp, output logic [7:0] d,
		output logic pb);
		realtime t0;
		d  = 8'h00;
		pb = 1'b0;
		wait (txd_i === 1'b0);
		t0 = $realtime;
		for (int k = 1; k <= nb + hp; k++) begin
			#(t0 + (k + 0.5) * bit_ns - $realtime);
			if (k <= nb)
				d[k-1] = txd_i;
			else
				pb = txd_i;
		end
	endtask : grab
endmodule : uart_far_end

// File: verif/uart_bridge_ctl_tb.sv
// Self-checking bench: suspend, registers, framing, buffer and flow.
// Assumes the far-end model drives the serial input pin.
`timescale 1ns/1ps
module uart_bridge_ctl_tb;
	import bridge_pkg::*;
	// ----------
	// Signals and instances
	// ----------
	logic              clk_i, nrst_i, suspend_det_i, resume_det_i;
	logic              bus_reset_i, config_done_i, remote_rouse_n_i;
	logic              wr_i, rd_i, tx_valid_i, rx_ready_i, rxd_i;
	logic              cts_n_i, dsr_n_i, dcd_n_i, ri_n_i, resume_req_o;
	logic              sleep_ind_high_o, sleep_ind_low_o, tx_ready_o;
	logic              rx_valid_o, txd_o, rts_n_o, dtr_n_o, pb;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o, rv;
	logic [7:0]        tx_data_i, rx_data_o, b, g;
	int                bad_count = 0, cmp_count = 0, wakes = 0;
	int                n, nb, hp, sh;
	real               bw;
	realtime           t0;
	int                rates [7] = '{300, 365, 366, 115200, 921600,
		3000000, 9600};

	uart_bridge_ctl uart_bridge_ctl_inst (
		.clk_i(clk_i), .nrst_i(nrst_i), .suspend_det_i(suspend_det_i),
		.resume_det_i(resume_det_i), .bus_reset_i(bus_reset_i),
		.config_done_i(config_done_i), .remote_rouse_n_i(remote_rouse_n_i),
		.resume_req_o(resume_req_o), .sleep_ind_high_o(sleep_ind_high_o),
		.sleep_ind_low_o(sleep_ind_low_o), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
		.tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
		.rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i), .txd_o(txd_o),
		.rxd_i(rxd_i), .rts_n_o(rts_n_o), .cts_n_i(cts_n_i),
		.dtr_n_o(dtr_n_o), .dsr_n_i(dsr_n_i), .dcd_n_i(dcd_n_i),
		.ri_n_i(ri_n_i)
	);
	uart_far_end uart_far_end_inst (
		.clk_i(clk_i), .txd_i(txd_o), .rts_n_i(rts_n_o),
		.dtr_n_i(dtr_n_o), .rxd_o(rxd_i)
	);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (resume_req_o === 1'b1) wakes++;
	// ----------
	// Tasks and expectations
	// ----------
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (e !== g) begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Tick jitter and edge alignment blur the frame end by a few cycles
	task automatic chk_near(input string nm, input int e, g);
		cmp_count++;
		if (g < e - 40 || g > e + 40) begin
			bad_count++;
			$display("BAD %s exp %0d got %0d", nm, e, g);
		end
	endtask : chk_near
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [3:0] a);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask : rdr
	task automatic evt(input int k);
		@(posedge clk_i);
		case (k)
			0: suspend_det_i <= 1'b1;
			1: resume_det_i <= 1'b1;
			2: bus_reset_i <= 1'b1;
			3: config_done_i <= 1'b1;
			default: remote_rouse_n_i <= 1'b0;
		endcase
		@(posedge clk_i);
		{suspend_det_i, resume_det_i, bus_reset_i, config_done_i} <= 4'h0;
		remote_rouse_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : evt
	task automatic ind(input logic e);
		chk("ind_high", e, sleep_ind_high_o);
		chk("ind_low", !e, sleep_ind_low_o);
	endtask : ind
	task automatic send_tx(input logic [7:0] d);
		@(posedge clk_i);
		tx_valid_i <= 1'b1;
		tx_data_i  <= d;
		n = 0;
		do @(negedge clk_i); while (tx_ready_o !== 1'b1 && ++n < 900);
		@(posedge clk_i);
		tx_valid_i <= 1'b0;
		t0 = $realtime;
	endtask : send_tx
	task automatic pop(input logic [7:0] e);
		n = 0;
		while (rx_valid_o !== 1'b1 && ++n < 900) @(negedge clk_i);
		chk("rx_data", e, rx_data_o);
		@(posedge clk_i);
		rx_ready_i <= 1'b1;
		@(posedge clk_i);
		rx_ready_i <= 1'b0;
		@(negedge clk_i);
	endtask : pop
	function automatic logic [31:0] dv(input int r);
		int p;
		p = (r <= 365) ? 4 : 1;
		return (48000000 + p * r) / (2 * p * r);
	endfunction : dv
	function automatic logic par(input logic [7:0] d, input int nb, pm);
		logic x;
		x = ^(d & (8'hff >> (8 - nb)));
		return (pm == 1) ? x : (pm == 2) ? !x : (pm == 3);
	endfunction : par
	// ----------
	// Test sequence
	// ----------
	initial begin
		{suspend_det_i, resume_det_i, bus_reset_i, config_done_i} = 4'h0;
		{wr_i, rd_i, tx_valid_i, rx_ready_i, nrst_i} = 5'h00;
		{cts_n_i, dsr_n_i, remote_rouse_n_i, dcd_n_i, ri_n_i} = 5'h07;
		addr_i    = 4'h0;
		wdata_i   = 32'h0;
		tx_data_i = 8'h00;
		void'($urandom(78733));
		rates[6] = $urandom_range(3000000, 300);
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		#1;
		ind(1'b1);
		chk("txd_idle", 1, txd_o);
		rdr(OFF_CTRL);
		chk("ctrl_rst", 32'h3, rv);
		rdr(OFF_BAUD);
		chk("baud_rst", 32'h2580, rv);
		rdr(4'h1);
		chk("unmapped", 0, rv);
		evt(3);
		ind(1'b0);
		evt(0);
		ind(1'b1);
		rdr(OFF_STAT);
		chk("stat_sleep", 1, rv[0]);
		evt(1);
		ind(1'b0);
		evt(0);
		evt(2);
		ind(1'b0);
		evt(0);
		evt(4);
		ind(1'b1);
		wr(OFF_CTRL, 32'h203);
		evt(4);
		ind(1'b0);
		chk("wake_req", 1, wakes);
		evt(0);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		#1;
		ind(1'b1);
		evt(3);
		ind(1'b0);
		foreach (rates[i]) begin
			wr(OFF_BAUD, rates[i]);
			rdr(OFF_DIV);
			chk("divider", dv(rates[i]), rv);
		end
		wr(OFF_BAUD, 3000000);
		bw = 2.0 * dv(3000000) * 1000.0 / 48.0;
		uart_far_end_inst.bit_ns = bw;
		for (int i = 0; i < 12; i++) begin
			nb = i % 4 + 5;
			hp = int'(i % 5 != 0);
			sh = (i % 3 == 0) ? 2 : (i % 3 == 1 && nb == 5) ? 3 : 4;
			sh = int'((2 * (1 + nb + hp) + sh) * bw / 2) + 20;
			wr(OFF_CTRL, {22'h0, 3'h0, 3'(i % 5), 2'(i % 3), 2'(i % 4)});
			b = 8'($urandom);
			send_tx(b);
			uart_far_end_inst.grab(nb, hp, g, pb);
			chk("tx_data", b & (8'hff >> (8 - nb)), g);
			chk("tx_parity", par(b, nb, i % 5), pb);
			n = 0;
			do @(negedge clk_i); while (tx_ready_o !== 1'b1 && ++n < 900);
			chk_near("tx_len", sh, int'($realtime - t0));
		end
		// Receiver stalls: third word must be refused, not overwrite
		wr(OFF_CTRL, 32'h13);
		b = 8'($urandom);
		g = 8'($urandom);
		uart_far_end_inst.send(b, 8, 1, ^b, 1'b1);
		uart_far_end_inst.send(g, 8, 1, ^g, 1'b1);
		uart_far_end_inst.send(8'h5a, 8, 1, 1'b0, 1'b1);
		pop(b);
		pop(g);
		uart_far_end_inst.send(8'ha5, 8, 1, 1'b1, 1'b1);
		pop(8'ha5);
		uart_far_end_inst.send(8'h3c, 8, 1, 1'b0, 1'b0);
		chk("rx_drop", 0, rx_valid_o);
		rdr(OFF_STAT);
		chk("err_set", 3'h7, rv[3:1]);
		wr(OFF_STAT, 32'he);
		rdr(OFF_STAT);
		chk("err_clear", 0, rv[3:1]);
		for (int m = 1; m < 3; m++) begin
			wr(OFF_CTRL, {22'h0, 1'b0, 2'(m), 7'h03});
			uart_far_end_inst.send(8'h42, 8, 0, 1'b0, 1'b1);
			chk("flow_stop", 1, m == 1 ? rts_n_o : dtr_n_o);
			pop(8'h42);
			chk("flow_go", 0, rts_n_o | dtr_n_o);
			@(posedge clk_i);
			cts_n_i <= (m == 1);
			dsr_n_i <= (m == 2);
			repeat (3) @(negedge clk_i);
			chk("tx_hold", 0, tx_ready_o);
			@(posedge clk_i);
			{cts_n_i, dsr_n_i} <= 2'b00;
		end
		wr(OFF_CTRL, 32'h183);
		uart_far_end_inst.send(XOFF_CHAR, 8, 0, 1'b0, 1'b1);
		chk("xoff_hold", 0, tx_ready_o);
		uart_far_end_inst.send(XON_CHAR, 8, 0, 1'b0, 1'b1);
		chk("xon_go", 1, tx_ready_o);
		chk("xon_eaten", 0, rx_valid_o);
		@(posedge clk_i);
		{dcd_n_i, ri_n_i} <= 2'b00;
		repeat (3) @(posedge clk_i);
		rdr(OFF_STAT);
		chk("modem", 4'hf, rv[8:5]);
		print_verdict();
	end
	initial begin
		#500000;
		bad_count++;
		print_verdict();
	end
endmodule : uart_bridge_ctl_tb
